// ===== verilog/serial_select_code_decoder.sv
// Serial select code decoder: framing, command capture, digit decode, activation
module serial_select_code_decoder #(
  parameter int unsigned SKIP_CYC   = ssd_pkg::SKIP_CYC,
  parameter int unsigned SAMPLE_CYC = ssd_pkg::SAMPLE_CYC,
  parameter int unsigned BIT_CYC    = ssd_pkg::BIT_CYC,
  parameter int unsigned DELAY_CYC  = ssd_pkg::DELAY_CYC,
  parameter int unsigned ACT_CYC    = ssd_pkg::ACT_CYC,
  parameter int unsigned CLEAR_CYC  = DELAY_CYC // Clear and delay share one length
) (
  // Clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     srst_i,
  // Serial line from the modem
  input  wire logic                     serial_rx_i,
  // Selection groups
  output logic [ssd_pkg::SEL_W-1:0]     high_sel_o,
  output logic [ssd_pkg::SEL_W-1:0]     low_sel_o,
  // Status
  output logic                          entry_en_o,
  output logic                          first_digit_lock_o,
  output logic                          second_digit_lock_o,
  output logic                          sample_win_o,
  // Peripheral control
  output logic                          activate_o,
  output logic                          clear_o
);

  logic                         rx_meta_reg;
  logic                         rxd_reg;
  logic                         rxd_prev_reg;
  logic                         fall;
  ssd_pkg::frame_t              frame_reg;
  logic [ssd_pkg::CNT_W-1:0]    frame_cnt_reg;
  logic [ssd_pkg::CNT_W-1:0]    bit_cnt_reg;
  logic [ssd_pkg::BITS_W-1:0]   bits_taken_reg;
  logic                         bit_tick;
  logic                         win_end;
  logic [ssd_pkg::CHAR_W-1:0]   rx_shift_reg;
  logic [ssd_pkg::CHAR_W-1:0]   ctrl_reg;
  logic [ssd_pkg::CHAR_W-1:0]   first_reg;
  logic [ssd_pkg::CHAR_W-1:0]   second_reg;
  ssd_pkg::lock_t               lock_reg;
  ssd_pkg::sel_t                sel_reg;
  ssd_pkg::act_t                act_reg;
  logic [ssd_pkg::CNT_W-1:0]    act_cnt_reg;
  logic                         clearing;
  logic                         accept;
  logic [ssd_pkg::DIG_W-1:0]    rx_digit;
  logic [ssd_pkg::SEL_W-1:0]    rx_hot;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  // Two-stage synchroniser and falling-edge detect on the synced level
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rx_meta_reg  <= 1'b1;
      rxd_reg      <= 1'b1;
      rxd_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg  <= serial_rx_i; // RULE23
      rxd_reg      <= rx_meta_reg;
      rxd_prev_reg <= rxd_reg;
    end
  end

  // Idle line is high, so the first falling edge after idle is the start bit
  assign fall = rxd_prev_reg & ~rxd_reg; // RULE1

  assign win_end = (frame_reg == ssd_pkg::F_SAMPLE) &&
                   (frame_cnt_reg == ssd_pkg::CNT_W'(SAMPLE_CYC - 1));

  // Skip and sampling windows
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      frame_reg     <= ssd_pkg::F_IDLE;
      frame_cnt_reg <= '0;
    end else begin
      case (frame_reg)
        ssd_pkg::F_IDLE: begin
          frame_cnt_reg <= '0;
          if (fall) begin
            frame_reg <= ssd_pkg::F_SKIP; // RULE2
          end
        end
        ssd_pkg::F_SKIP: begin
          if (frame_cnt_reg == ssd_pkg::CNT_W'(SKIP_CYC - 1)) begin
            frame_reg     <= ssd_pkg::F_SAMPLE; // RULE3
            frame_cnt_reg <= '0;
          end else begin
            frame_cnt_reg <= frame_cnt_reg + 1'b1;
          end
        end
        ssd_pkg::F_SAMPLE: begin
          // Edges inside the window are data, not start bits
          if (win_end) begin // RULE21
            frame_reg     <= ssd_pkg::F_IDLE;
            frame_cnt_reg <= '0;
          end else begin
            frame_cnt_reg <= frame_cnt_reg + 1'b1;
          end
        end
        default: begin
          frame_reg     <= ssd_pkg::F_IDLE;
          frame_cnt_reg <= '0;
        end
      endcase
    end
  end

  // Bit clock: first tick as the window opens, then one per bit period
  assign bit_tick = (frame_reg == ssd_pkg::F_SAMPLE) && (bit_cnt_reg == '0) &&
                    (bits_taken_reg != ssd_pkg::CHAR_BITS);

  always_ff @(posedge core_clk_i) begin
    if (srst_i || frame_reg != ssd_pkg::F_SAMPLE) begin
      bit_cnt_reg    <= '0;
      bits_taken_reg <= '0;
    end else begin
      if (bit_cnt_reg == ssd_pkg::CNT_W'(BIT_CYC - 1)) begin // RULE4
        bit_cnt_reg <= '0;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
      if (bit_tick) begin
        bits_taken_reg <= bits_taken_reg + 1'b1;
      end
    end
  end

  // First received bit ends up in the top bit
  always_ff @(posedge core_clk_i) begin
    if (srst_i || frame_reg == ssd_pkg::F_IDLE) begin
      rx_shift_reg <= ssd_pkg::CHAR_ZERO;
    end else if (bit_tick) begin
      rx_shift_reg <= {rx_shift_reg[ssd_pkg::CHAR_W-2:0], rxd_reg}; // RULE5
    end
  end

  // Low-order data bit arrives first
  assign rx_digit = {rx_shift_reg[4], rx_shift_reg[5], rx_shift_reg[6], rx_shift_reg[7]}; // RULE22

  generate
    for (genvar i = 0; i < ssd_pkg::SEL_W; i++) begin : g_hot
      assign rx_hot[i] = (rx_digit == ssd_pkg::DIG_W'(i)); // RULE10
    end
  endgenerate

  assign clearing = (act_reg == ssd_pkg::A_CLEAR);
  // Characters are only judged once the whole window has passed
  assign accept   = win_end && (act_reg == ssd_pkg::A_IDLE); // RULE6

  // Command and digit stages
  always_ff @(posedge core_clk_i) begin
    if (srst_i || clearing) begin // RULE16 RULE18
      ctrl_reg   <= ssd_pkg::CHAR_ZERO;
      first_reg  <= ssd_pkg::CHAR_ZERO;
      second_reg <= ssd_pkg::CHAR_ZERO;
      lock_reg   <= '0;
      sel_reg    <= '0;
    end else if (accept) begin
      if (!lock_reg.entry) begin
        // Anything but the control character is dropped
        if (rx_shift_reg == ssd_pkg::CTRL_X) begin // RULE20 RULE24
          ctrl_reg       <= rx_shift_reg;
          lock_reg.entry <= 1'b1; // RULE7 RULE8
        end
      end else if (!lock_reg.first) begin // RULE9
        first_reg      <= rx_shift_reg;
        sel_reg.high   <= rx_hot; // RULE19
        lock_reg.first <= 1'b1; // RULE11
      end else if (!lock_reg.second) begin // RULE12
        second_reg      <= rx_shift_reg;
        sel_reg.low     <= rx_hot; // RULE13
        lock_reg.second <= 1'b1;
      end
    end
  end

  // Activation sequencer
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      act_reg     <= ssd_pkg::A_IDLE;
      act_cnt_reg <= '0;
    end else begin
      case (act_reg)
        ssd_pkg::A_IDLE: begin
          act_cnt_reg <= '0;
          if (lock_reg.second) begin
            act_reg <= ssd_pkg::A_DELAY; // RULE14
          end
        end
        ssd_pkg::A_DELAY: begin
          if (act_cnt_reg == ssd_pkg::CNT_W'(DELAY_CYC - 1)) begin
            act_reg     <= ssd_pkg::A_ACT;
            act_cnt_reg <= '0;
          end else begin
            act_cnt_reg <= act_cnt_reg + 1'b1;
          end
        end
        ssd_pkg::A_ACT: begin
          if (act_cnt_reg == ssd_pkg::CNT_W'(ACT_CYC - 1)) begin // RULE15
            act_reg     <= ssd_pkg::A_CLEAR; // RULE17
            act_cnt_reg <= '0;
          end else begin
            act_cnt_reg <= act_cnt_reg + 1'b1;
          end
        end
        ssd_pkg::A_CLEAR: begin
          if (act_cnt_reg == ssd_pkg::CNT_W'(CLEAR_CYC - 1)) begin // RULE16
            act_reg     <= ssd_pkg::A_IDLE;
            act_cnt_reg <= '0;
          end else begin
            act_cnt_reg <= act_cnt_reg + 1'b1;
          end
        end
        default: begin
          act_reg     <= ssd_pkg::A_IDLE;
          act_cnt_reg <= '0;
        end
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      activate_o   <= 1'b0;
      clear_o      <= 1'b0;
      sample_win_o <= 1'b0;
    end else begin
      activate_o   <= (act_reg == ssd_pkg::A_ACT);
      clear_o      <= clearing;
      sample_win_o <= (frame_reg == ssd_pkg::F_SAMPLE);
    end
  end

  assign high_sel_o          = sel_reg.high;
  assign low_sel_o           = sel_reg.low;
  assign entry_en_o          = lock_reg.entry;
  assign first_digit_lock_o  = lock_reg.first;
  assign second_digit_lock_o = lock_reg.second;

  AST_SKIP_START: assert property ( // RULE2
    frame_reg == ssd_pkg::F_IDLE && fall |=> frame_reg == ssd_pkg::F_SKIP)
    else $error("start edge did not open skip window");

  AST_SKIP_TO_SAMPLE: assert property ( // RULE3
    frame_reg == ssd_pkg::F_SKIP && frame_cnt_reg == ssd_pkg::CNT_W'(SKIP_CYC - 1)
    |=> frame_reg == ssd_pkg::F_SAMPLE && frame_cnt_reg == '0)
    else $error("skip window did not hand over to sampling");

  AST_FIRST_TICK: assert property ( // RULE4
    $rose(frame_reg == ssd_pkg::F_SAMPLE) |-> bit_tick)
    else $error("bit clock did not start with window");

  AST_EIGHT_BITS: assert property ( // RULE5
    win_end |-> bits_taken_reg == ssd_pkg::CHAR_BITS)
    else $error("window ended without eight bits");

  AST_NO_RESTART: assert property ( // RULE21
    frame_reg == ssd_pkg::F_SAMPLE && !win_end |=> frame_reg == ssd_pkg::F_SAMPLE)
    else $error("sampling window cut short");

  AST_ENTRY_ONLY_AT_END: assert property ( // RULE6
    $rose(lock_reg.entry) |-> $past(win_end) && $past(rx_shift_reg) == ssd_pkg::CTRL_X)
    else $error("entry enable rose outside window end");

  AST_ENTRY_HOLD: assert property ( // RULE8
    lock_reg.entry && !clearing |=> lock_reg.entry)
    else $error("entry enable dropped before clear");

  AST_ONE_HOT: assert property ( // RULE10
    lock_reg.first |-> $onehot0(sel_reg.high))
    else $error("high group not one-hot");

  AST_SECOND_GATED: assert property ( // RULE12
    $rose(lock_reg.second) |-> $past(lock_reg.entry) && $past(lock_reg.first))
    else $error("second digit taken without both gates");

  AST_FIRST_FROZEN: assert property ( // RULE11
    lock_reg.first && !clearing |=> $stable(sel_reg.high) && $stable(first_reg))
    else $error("first digit changed after lock");

  AST_ACT_AFTER_DELAY: assert property ( // RULE14
    act_reg == ssd_pkg::A_DELAY && act_cnt_reg == ssd_pkg::CNT_W'(DELAY_CYC - 1)
    |=> act_reg == ssd_pkg::A_ACT ##1 activate_o)
    else $error("activation did not follow delay");

  AST_CLEAR_ZEROES: assert property ( // RULE16
    clearing |=> lock_reg == '0 && sel_reg == '0 && ctrl_reg == ssd_pkg::CHAR_ZERO)
    else $error("clear left registers set");

  AST_HOLD_TO_CLEAR: assert property ( // RULE17
    act_reg == ssd_pkg::A_ACT |=> $stable(sel_reg) || act_reg == ssd_pkg::A_CLEAR)
    else $error("selection moved during activation");

  AST_STRAY_IGNORED: assert property ( // RULE24
    accept && !lock_reg.entry && rx_shift_reg != ssd_pkg::CTRL_X
    |=> !lock_reg.entry && $stable(sel_reg) && $stable(ctrl_reg))
    else $error("stray character changed state");

  AST_SAMPLE_OUT: assert property ( // RULE3
    sample_win_o == $past(frame_reg == ssd_pkg::F_SAMPLE))
    else $error("sampling window output out of step");

  AST_SYNC_PATH: assert property ( // RULE23
    !$past(srst_i) && !$past(srst_i, 2) |-> rxd_reg == $past(serial_rx_i, 2))
    else $error("synchroniser did not pass the line through");

  AST_FIRST_GATED: assert property ( // RULE9
    $rose(lock_reg.first) |-> $past(lock_reg.entry))
    else $error("first digit taken without entry enable");

  AST_CTRL_MATCH: assert property ( // RULE20
    $rose(lock_reg.entry) |-> ctrl_reg == ssd_pkg::CTRL_X)
    else $error("entry enable without control character");

  AST_DIGIT_VALUE: assert property ( // RULE22
    $rose(lock_reg.first) |->
    sel_reg.high[0] == (first_reg[ssd_pkg::CHAR_W-1 -: ssd_pkg::DIG_W] == 4'h0) &&
    sel_reg.high[1] == (first_reg[ssd_pkg::CHAR_W-1 -: ssd_pkg::DIG_W] == 4'h8))
    else $error("high group does not match first received bits");

  AST_LOW_ONE_HOT: assert property ( // RULE13
    lock_reg.second |-> $onehot0(sel_reg.low))
    else $error("low group not one-hot");

  AST_ACT_ONLY_IN_ACT: assert property ( // RULE15
    activate_o |-> $past(act_reg == ssd_pkg::A_ACT))
    else $error("activation outside its state");

  AST_ACT_END: assert property ( // RULE15
    act_reg == ssd_pkg::A_ACT && act_cnt_reg == ssd_pkg::CNT_W'(ACT_CYC - 1)
    |=> act_reg == ssd_pkg::A_CLEAR ##1 !activate_o && clear_o)
    else $error("activation did not hand over to clear");

  AST_CLEAR_END: assert property ( // RULE18
    act_reg == ssd_pkg::A_CLEAR && act_cnt_reg == ssd_pkg::CNT_W'(CLEAR_CYC - 1)
    |=> act_reg == ssd_pkg::A_IDLE ##1 !clear_o)
    else $error("clear pulse did not end");

  COV_ENTRY: cover property ($rose(lock_reg.entry));
  COV_FIRST: cover property ($rose(lock_reg.first));
  COV_SECOND: cover property ($rose(lock_reg.second));
  COV_ACTIVATE: cover property ($rose(activate_o));
  COV_CLEAR_DONE: cover property ($fell(clear_o));

endmodule : serial_select_code_decoder

// ===== verilog/ssd_pkg.sv
// Constants, types and timing for the serial select code decoder
// Operation
// RULE1 - Idle serial line rests high (marking)
// RULE2 - Start falling edge opens 11 ms skip window
// RULE3 - Skip end opens 68 ms sampling window
// RULE4 - Sampling window starts 122 Hz bit clock
// RULE5 - Eight data bits shift in during window
// RULE6 - Control decode held low until window ends
// RULE7 - Control-X routes data onward, blocks command register
// RULE8 - Entry enable holds until clear pulse
// RULE9 - First digit accepts data only when entry enabled
// RULE10 - Each digit decodes to one of ten
// RULE11 - First digit lock blocks further first-digit input
// RULE12 - Second digit needs entry and first lock
// RULE13 - Second digit drives low-order group likewise
// RULE14 - Second lock starts activation after 50 ms
// RULE15 - Activation is one six second high pulse
// RULE16 - Activation end fires 50 ms clear of registers
// RULE17 - Selections held until activation ends, then cleared
// RULE18 - After clear, ready for new command
// RULE19 - First digit high-order, second digit low-order
// RULE20 - Control match on reception-order pattern 00011001
// RULE21 - Edges during sampling never restart the window
// RULE22 - Digit value from first four received bits
// RULE23 - Input synchronised, all timing from cycle counters
// RULE24 - Stray characters when idle change nothing
package ssd_pkg;

  localparam int unsigned CLK_HZ    = 125_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned SKIP_US   = 11_000;
  localparam int unsigned SAMPLE_US = 68_000;
  localparam int unsigned BIT_HZ    = 122;
  localparam int unsigned DELAY_US  = 50_000;
  localparam int unsigned ACT_S     = 6;
  localparam int unsigned CLEAR_US  = 50_000;

  localparam int unsigned SKIP_CYC   = SKIP_US * CLK_PER_US;
  localparam int unsigned SAMPLE_CYC = SAMPLE_US * CLK_PER_US;
  localparam int unsigned BIT_CYC    = CLK_HZ / BIT_HZ;
  localparam int unsigned DELAY_CYC  = DELAY_US * CLK_PER_US;
  localparam int unsigned ACT_CYC    = ACT_S * CLK_HZ;
  localparam int unsigned CLEAR_CYC  = CLEAR_US * CLK_PER_US;

  localparam int unsigned CNT_W  = 30;
  localparam int unsigned CHAR_W = 8;
  localparam int unsigned BITS_W = 4;
  localparam int unsigned SEL_W  = 10;
  localparam int unsigned DIG_W  = 4;

  localparam logic [CHAR_W-1:0] CTRL_X    = 8'h19;
  localparam logic [CHAR_W-1:0] CHAR_ZERO = 8'h00;
  localparam logic [SEL_W-1:0]  SEL_NONE  = 10'h000;
  localparam logic [BITS_W-1:0] CHAR_BITS = 4'h8;

  typedef enum logic [1:0] {
    F_IDLE   = 2'b00,
    F_SKIP   = 2'b01,
    F_SAMPLE = 2'b10
  } frame_t;

  typedef enum logic [1:0] {
    A_IDLE  = 2'b00,
    A_DELAY = 2'b01,
    A_ACT   = 2'b10,
    A_CLEAR = 2'b11
  } act_t;

  typedef struct packed {
    logic [SEL_W-1:0] high;
    logic [SEL_W-1:0] low;
  } sel_t;

  typedef struct packed {
    logic entry;
    logic first;
    logic second;
  } lock_t;

endpackage : ssd_pkg

// ===== test/serial_line_model.sv
// Modem receive line model that frames characters onto the serial line
module serial_line_model #(
  parameter int unsigned LINE_BIT = 8
) (
  // Clock
  input  wire logic core_clk_i,
  // Serial line
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    line_o = 1'b1;
  end

  // Start bit, eight bits first-received first, one stop bit, then idle gap
  task automatic send_char(input logic [7:0] c);
    logic [9:0] frame;
    frame = {1'b0, c, 1'b1};
    for (int i = 9; i >= 0; i--) begin
      @(negedge core_clk_i);
      line_o = frame[i];
      repeat (LINE_BIT - 1) @(negedge core_clk_i);
    end
    repeat (3 * LINE_BIT) @(negedge core_clk_i);
  endtask : send_char
endmodule : serial_line_model

// ===== test/testbench.sv
// Self-checking bench for the serial select code decoder
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned SKIP   = 11;
  localparam int unsigned SAMPLE = 68;
  localparam int unsigned BITP   = 8;
  localparam int unsigned DLY    = 5;
  localparam int unsigned ACT    = 60;
  // Clear length follows the delay parameter in the design
  localparam int unsigned CLR    = DLY;

  logic                      core_clk_i;
  logic                      srst_i;
  logic                      serial_rx;
  logic [ssd_pkg::SEL_W-1:0] high_sel;
  logic [ssd_pkg::SEL_W-1:0] low_sel;
  logic                      entry_en;
  logic                      first_digit_lock;
  logic                      second_digit_lock;
  logic                      sample_win;
  logic                      activate;
  logic                      clear;
  logic [3:0]                mon;
  int                        err_count;
  int                        checks_done;
  int                        n;

  assign mon = {activate, clear, second_digit_lock, sample_win};

  serial_select_code_decoder #(
    .SKIP_CYC   (SKIP),
    .SAMPLE_CYC (SAMPLE),
    .BIT_CYC    (BITP),
    .DELAY_CYC  (DLY),
    .ACT_CYC    (ACT)
  ) dut_u (
    .core_clk_i          (core_clk_i),
    .srst_i              (srst_i),
    .serial_rx_i         (serial_rx),
    .high_sel_o          (high_sel),
    .low_sel_o           (low_sel),
    .entry_en_o          (entry_en),
    .first_digit_lock_o  (first_digit_lock),
    .second_digit_lock_o (second_digit_lock),
    .sample_win_o        (sample_win),
    .activate_o          (activate),
    .clear_o             (clear)
  );

  // Default line bit time equals BITP, so every tick lands mid-bit
  serial_line_model line_u (
    .core_clk_i (core_clk_i),
    .line_o     (serial_rx)
  );

  always #4 core_clk_i = ~core_clk_i;

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic check(input string nm, input logic [9:0] exp, input logic [9:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // Counts rising edges until the watched output reaches the level
  task automatic wait_lvl(input int idx, input logic lvl, output int cnt);
    cnt = 0;
    do begin
      @(posedge core_clk_i);
      #1;
      cnt++;
    end while (mon[idx] !== lvl && cnt < 2000);
    if (mon[idx] !== lvl) begin
      err_count++;
      $display("CHECK FAILED wait %0d expected %b seen %b", idx, lvl, mon[idx]);
      conclude();
    end
  endtask : wait_lvl

  // Digit value in the first four bits, first received is bit 0
  function automatic logic [7:0] dchar(input logic [3:0] d);
    return {d[0], d[1], d[2], d[3], 4'b1101};
  endfunction : dchar

  initial begin
    core_clk_i = 1'b0;
    srst_i = 1'b1;
    err_count = 0;
    checks_done = 0;
    repeat (5) @(negedge core_clk_i);
    srst_i = 1'b0;
    check("high_sel", 10'h000, high_sel);
    check("activate", 10'h000, 10'(activate));
    // Framing: many falling edges inside the character
    fork
      line_u.send_char(8'h55);
      begin
        @(negedge core_clk_i);
        wait_lvl(0, 1'b1, n);
        // Two sync flops, the frame register entering skip and the output flop add four
        check("win_start", 10'(SKIP + 4), 10'(n));
        wait_lvl(0, 1'b0, n);
        check("win_len", 10'(SAMPLE), 10'(n));
      end
    join
    line_u.send_char(8'h18);
    line_u.send_char(8'h98);
    check("entry_stray", 10'h000, 10'(entry_en));
    check("high_stray", 10'h000, high_sel);
    $display("test framing and stray characters done");
    for (int d = 0; d < 10; d++) begin
      line_u.send_char(ssd_pkg::CTRL_X);
      check("entry", 10'h001, 10'(entry_en));
      check("lock1_early", 10'h000, 10'(first_digit_lock));
      line_u.send_char(dchar(4'(d)));
      check("lock1", 10'h001, 10'(first_digit_lock));
      check("high_sel", 10'h001 << d, high_sel);
      check("low_early", 10'h000, low_sel);
      fork
        line_u.send_char(dchar(4'(9 - d)));
        begin
          wait_lvl(1, 1'b1, n);
          wait_lvl(3, 1'b1, n);
          check("act_delay", 10'(DLY + 2), 10'(n));
          check("low_sel", 10'h001 << (9 - d), low_sel);
          check("high_hold", 10'h001 << d, high_sel);
          check("entry_hold", 10'h001, 10'(entry_en));
          wait_lvl(3, 1'b0, n);
          check("act_len", 10'(ACT), 10'(n));
          check("clear_start", 10'h001, 10'(clear));
          wait_lvl(2, 1'b0, n);
          check("clear_len", 10'(CLR), 10'(n));
          check("sel_cleared", 10'h000, high_sel | low_sel);
          check("regs_cleared", 10'h000, 10'({entry_en, first_digit_lock}));
        end
      join
      $display("test command %0d%0d done", d, 9 - d);
    end
    conclude();
  end
endmodule : testbench
